// file: verilog/bie_pkg.sv
// bie_pkg: shared constants for the 1553 event flag logic
// assumes a 250 MHz core clock; configuration words arrive as plain 16-bit inputs
package bie_pkg;

    // ----
    // clock and timing
    // ----
    localparam int CLK_PERIOD_PS      = 4000;
    localparam int TX_TIMEOUT_US      = 668;
    localparam int TX_TIMEOUT_CYC     = (TX_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
    localparam int HS_WIN_20M_NS      = 4400;
    localparam int HS_WIN_16M_NS      = 4000;
    localparam int HS_WIN_12M_NS      = 3500;
    localparam int HS_WIN_10M_NS      = 3200;
    localparam int HS_WIN_20M_CYC     = (HS_WIN_20M_NS * 1000) / CLK_PERIOD_PS;
    localparam int HS_WIN_16M_CYC     = (HS_WIN_16M_NS * 1000) / CLK_PERIOD_PS;
    localparam int HS_WIN_12M_CYC     = (HS_WIN_12M_NS * 1000) / CLK_PERIOD_PS;
    localparam int HS_WIN_10M_CYC     = (HS_WIN_10M_NS * 1000) / CLK_PERIOD_PS;
    localparam int WATCH_W            = 18;

    // ----
    // terminal clock select
    // ----
    localparam logic [1:0] TCLK_10M   = 2'h0;
    localparam logic [1:0] TCLK_12M   = 2'h1;
    localparam logic [1:0] TCLK_16M   = 2'h2;
    localparam logic [1:0] TCLK_20M   = 2'h3;

    // ----
    // operating mode
    // ----
    localparam logic [2:0] MODE_BC    = 3'h0;
    localparam logic [2:0] MODE_RT    = 3'h1;
    localparam logic [2:0] MODE_WMON  = 3'h2;
    localparam logic [2:0] MODE_MMON  = 3'h3;
    localparam logic [2:0] MODE_RTMON = 3'h4;

    // ----
    // configuration bit positions
    // ----
    localparam int CFG2_EXT_IRQ       = 15;
    localparam int CFG2_INV_OVERWRITE = 11;
    localparam int CFG3_EXT_FEATURE   = 15;
    localparam int CFG3_CMD_SZ_HI     = 14;
    localparam int CFG3_CMD_SZ_LO     = 13;
    localparam int CFG3_MON_SZ_HI     = 12;
    localparam int CFG3_MON_SZ_LO     = 11;
    localparam int CFG3_DAT_SZ_HI     = 10;
    localparam int CFG3_DAT_SZ_LO     = 8;
    localparam int CFG3_EXT_MODECODE  = 0;
    localparam int CFG4_WIDE_CTRL     = 12;
    localparam int CFG4_BCAST_XOR     = 11;
    localparam int CTRL_EOM_REQ       = 4;
    localparam int CTRL_BCAST_MASK    = 5;

    // ----
    // event flag register bits
    // ----
    localparam int EV_MASTER          = 15;
    localparam int EV_RAM_PARITY      = 14;
    localparam int EV_TX_TIMEOUT      = 13;
    localparam int EV_CMD_WRAP        = 12;
    localparam int EV_MON_CMD_WRAP    = 11;
    localparam int EV_MON_DAT_WRAP    = 10;
    localparam int EV_HS_FAIL         = 9;
    localparam int EV_RETRY           = 8;
    localparam int EV_ADDR_PARITY     = 7;
    localparam int EV_TTAG_WRAP       = 6;
    localparam int EV_CBUF_WRAP       = 5;
    localparam int EV_CTRL_EOM        = 4;
    localparam int EV_END_FRAME       = 3;
    localparam int EV_FORMAT          = 2;
    localparam int EV_STATUS_SET      = 1;
    localparam int EV_MSG_DONE        = 0;
    localparam int EV_BASIC_TOP       = 7;
    localparam logic [15:0] FLAG_RESET = 16'h0000;

    // ----
    // 1553 words
    // ----
    localparam logic [15:0] STS_CHECK_MASK = 16'h071f;
    localparam logic [15:0] STS_BCAST_BIT  = 16'h0010;
    localparam logic [15:0] COUNT_END      = 16'hffff;
    localparam logic [15:0] TTAG_TOP       = 16'hffff;

    // ----
    // stack sizes as log2 of words
    // ----
    localparam logic [4:0] CMD_LOG2_BASE  = 5'h08;
    localparam logic [4:0] MON_LOG2_BASE  = 5'h08;
    localparam logic [4:0] DAT_LOG2_BASE  = 5'h09;
    localparam logic [4:0] STACK_LOG2_MAX = 5'h10;

endpackage

// file: verilog/bie_window_watch.sv
// bie_window_watch: counts cycles while a wait condition holds, pulses once on overrun
// assumes limit_i is held steady while armed
`timescale 1ns/1ns
`default_nettype none
module bie_window_watch (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        arm_i,
    input  wire logic [bie_pkg::WATCH_W-1:0] limit_i,
    output logic                             overrun_o
);
    import bie_pkg::*;

    typedef struct packed {
        logic [WATCH_W-1:0] cnt;
        logic               fired;
        logic               pulse;
    } bie_watch_t;

    bie_watch_t st;
    bie_watch_t next_st;

    always_comb begin
        next_st = st;
        next_st.pulse = 1'b0;
        if (!arm_i) begin
            next_st.cnt = '0;
            next_st.fired = 1'b0;
        end else if (!st.fired) begin
            if (st.cnt >= limit_i) begin
                next_st.pulse = 1'b1;
                next_st.fired = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign overrun_o = st.pulse;
endmodule
`default_nettype wire

// file: verilog/bie_stack_wrap.sv
// bie_stack_wrap: tracks a stack word offset and pulses when it wraps to the base
// assumes one push pulse per word stored; size_log2_i at most 16
`timescale 1ns/1ns
`default_nettype none
module bie_stack_wrap (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       push_i,
    input  wire logic [4:0] size_log2_i,
    output logic            wrap_o
);
    import bie_pkg::*;

    typedef struct packed {
        logic [15:0] offset;
        logic        pulse;
    } bie_wrap_t;

    bie_wrap_t   st;
    bie_wrap_t   next_st;
    logic [15:0] top;

    assign top = 16'hffff >> (STACK_LOG2_MAX - size_log2_i);

    always_comb begin
        next_st = st;
        next_st.pulse = 1'b0;
        if (push_i) begin
            if ((st.offset & top) == top) begin
                next_st.offset = '0;
                next_st.pulse = 1'b1;
            end else begin
                next_st.offset = (st.offset + 16'h0001) & top;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wrap_o = st.pulse;
endmodule
`default_nettype wire

// file: verilog/bie_event_logic.sv
// bie_event_logic: event flag register and interrupt request of a 1553 terminal
// assumes event inputs are one-cycle pulses from the protocol engines,
// configuration words held steady, all inputs synchronous to core_clk_i
//
// Function
// - flag encoder transmitting longer than 668 us
// - extended flags need both extended enables
// - flag command stack wrap, size by bits 14:13
// - flag monitor command stack wrap, bits 12:11
// - flag monitor data stack wrap, bits 10:8
// - handshake failure only transparent mode, clock-scaled window
// - grant missing within window after request: failure
// - strobe low past window after ready: failure
// - retry flag after one to three retries
// - even address parity raises address parity flag
// - parity flag re-arms on new fault or mask
// - flag time tag wrap ffff to 0000
// - flag circular buffer rollover when requested, terminal mode
// - overwrite bit picks immediate or valid-end rollover
// - control word end-of-message in terminal or controller
// - end of frame at count ffff, not on abort
// - loop test failure on transmitted words flags format
// - validation error or response timeout flags format
// - controller flags unexpected status word bits
// - enabled mode codes flag at message end
// - word monitor flags trigger pattern match
// - end-of-message flag on every completed message except in word monitor mode
// - extended sets unmasked; basic mode masks bits 7:0
// - bit 15 mirrors the interrupt request
`timescale 1ns/1ns
`default_nettype none
module bie_event_logic #(
    parameter int TX_LIMIT = bie_pkg::TX_TIMEOUT_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // configuration and mask registers
    input  wire logic [15:0] cfg2_i,
    input  wire logic [15:0] cfg3_i,
    input  wire logic [15:0] cfg4_i,
    input  wire logic [15:0] irq_mask_i,
    input  wire logic [2:0]  mode_i,
    input  wire logic [1:0]  term_clk_sel_i,
    input  wire logic        transparent_mode_i,
    input  wire logic        ext_mem_mgmt_i,
    // flag register access
    input  wire logic        flag_read_i,
    input  wire logic        auto_clear_i,
    input  wire logic        irq_reset_i,
    // pins
    input  wire logic [4:0]  terminal_address_in_i,
    input  wire logic        terminal_address_parity_in_i,
    input  wire logic        transfer_request_out_i,
    input  wire logic        transfer_grant_in_n_i,
    input  wire logic        host_ready_out_n_i,
    input  wire logic        host_strobe_in_n_i,
    // engine events
    input  wire logic        encoder_active_i,
    input  wire logic        ram_parity_err_i,
    input  wire logic        cmd_stack_push_i,
    input  wire logic        mon_cmd_push_i,
    input  wire logic        mon_dat_push_i,
    input  wire logic        retry_done_i,
    input  wire logic [1:0]  retry_count_i,
    input  wire logic        ttag_tick_i,
    input  wire logic        msg_end_i,
    input  wire logic        msg_valid_i,
    input  wire logic        cbuf_top_access_i,
    input  wire logic        sa_rollover_req_i,
    input  wire logic        sa_eom_req_i,
    input  wire logic [15:0] ctrl_word_i,
    input  wire logic        msg_count_wr_i,
    input  wire logic [15:0] msg_count_i,
    input  wire logic        stop_abort_i,
    input  wire logic        echo_check_i,
    input  wire logic        transmitting_i,
    input  wire logic        rt_broadcast_i,
    input  wire logic        echo_valid_i,
    input  wire logic        echo_sync_ok_i,
    input  wire logic [15:0] last_tx_word_i,
    input  wire logic [15:0] last_echo_word_i,
    input  wire logic        msg_error_i,
    input  wire logic        resp_timeout_i,
    input  wire logic        status_strobe_i,
    input  wire logic [15:0] status_word_i,
    input  wire logic        mode_code_end_i,
    input  wire logic        mode_code_enabled_i,
    input  wire logic        cmd_word_strobe_i,
    input  wire logic        cmd_word_valid_i,
    input  wire logic [15:0] cmd_word_i,
    input  wire logic [15:0] trigger_pattern_i,
    output logic [15:0]      event_flag_register_o,
    output logic             irq_o,
    output logic [15:0]      time_tag_o
);
    import bie_pkg::*;

    // ----
    // decode helpers
    // ----
    function automatic logic [WATCH_W-1:0] hs_window(input logic [1:0] sel);
        case (sel)
            TCLK_20M: hs_window = WATCH_W'(HS_WIN_20M_CYC);
            TCLK_16M: hs_window = WATCH_W'(HS_WIN_16M_CYC);
            TCLK_12M: hs_window = WATCH_W'(HS_WIN_12M_CYC);
            default:  hs_window = WATCH_W'(HS_WIN_10M_CYC);
        endcase
    endfunction

    function automatic logic is_mode(input logic [2:0] m, input logic [2:0] want);
        is_mode = (m == want);
    endfunction

    typedef struct packed {
        logic [14:0] flags;
        logic        irq;
        logic [15:0] ttag;
        logic        fault_d;
        logic        mask7_d;
        logic        cbuf_pend;
    } bie_state_t;

    bie_state_t st;
    bie_state_t next_st;

    logic        ext;
    logic        enh;
    logic        in_bc;
    logic        in_rt;
    logic        in_wmon;
    logic        in_mmon;
    logic        tx_to;
    logic        hs_grant_to;
    logic        hs_strobe_to;
    logic        cmd_wrap;
    logic        mon_wrap;
    logic        dat_wrap;
    logic [4:0]  cmd_log2;
    logic [4:0]  mon_log2;
    logic [4:0]  dat_log2;
    logic [WATCH_W-1:0] hs_limit;
    logic [14:0] ev;
    logic [15:0] sts_expect;
    logic        parity_fault;

    assign enh     = cfg3_i[CFG3_EXT_FEATURE];
    assign ext     = enh & cfg2_i[CFG2_EXT_IRQ];
    assign in_bc   = is_mode(mode_i, MODE_BC);
    assign in_rt   = is_mode(mode_i, MODE_RT) | is_mode(mode_i, MODE_RTMON);
    assign in_wmon = is_mode(mode_i, MODE_WMON);
    assign in_mmon = is_mode(mode_i, MODE_MMON) | is_mode(mode_i, MODE_RTMON);

    // ----
    // watchdogs
    // ----
    assign hs_limit = hs_window(term_clk_sel_i);

    bie_window_watch u_tx_watch (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .arm_i      (encoder_active_i),
        .limit_i    (WATCH_W'(TX_LIMIT)),
        .overrun_o  (tx_to)
    );

    bie_window_watch u_grant_watch (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .arm_i      (transparent_mode_i & transfer_request_out_i & transfer_grant_in_n_i),
        .limit_i    (hs_limit),
        .overrun_o  (hs_grant_to)
    );

    bie_window_watch u_strobe_watch (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .arm_i      (transparent_mode_i & ~host_ready_out_n_i & ~host_strobe_in_n_i),
        .limit_i    (hs_limit),
        .overrun_o  (hs_strobe_to)
    );

    // ----
    // stack wrap trackers
    // ----
    assign cmd_log2 = CMD_LOG2_BASE + {3'h0, cfg3_i[CFG3_CMD_SZ_HI:CFG3_CMD_SZ_LO]};
    assign mon_log2 = MON_LOG2_BASE + {2'h0, cfg3_i[CFG3_MON_SZ_HI:CFG3_MON_SZ_LO], 1'b0};
    assign dat_log2 = DAT_LOG2_BASE + {2'h0, cfg3_i[CFG3_DAT_SZ_HI:CFG3_DAT_SZ_LO]};

    bie_stack_wrap u_cmd_wrap (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .push_i      (cmd_stack_push_i),
        .size_log2_i (cmd_log2),
        .wrap_o      (cmd_wrap)
    );

    bie_stack_wrap u_mon_wrap (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .push_i      (mon_cmd_push_i),
        .size_log2_i (mon_log2),
        .wrap_o      (mon_wrap)
    );

    bie_stack_wrap u_dat_wrap (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .push_i      (mon_dat_push_i),
        .size_log2_i (dat_log2),
        .wrap_o      (dat_wrap)
    );

    // ----
    // raw events
    // ----
    assign parity_fault = ~(^{terminal_address_in_i, terminal_address_parity_in_i});

    always_comb begin
        sts_expect = 16'h0000;
        if (!cfg4_i[CFG4_BCAST_XOR] && ctrl_word_i[CTRL_BCAST_MASK]) begin
            sts_expect = STS_BCAST_BIT;
        end
    end

    always_comb begin
        ev = '0;
        ev[EV_RAM_PARITY]   = ram_parity_err_i;
        ev[EV_TX_TIMEOUT]   = tx_to;
        ev[EV_CMD_WRAP]     = cmd_wrap & (in_bc | in_rt);
        ev[EV_MON_CMD_WRAP] = mon_wrap & in_mmon;
        ev[EV_MON_DAT_WRAP] = dat_wrap & (in_wmon | in_mmon);
        ev[EV_HS_FAIL]      = transparent_mode_i & (hs_grant_to | hs_strobe_to);
        ev[EV_RETRY]        = in_bc & retry_done_i & (retry_count_i != 2'h0);
        // only a fresh fault, or the mask bit re-armed under a fault
        ev[EV_ADDR_PARITY]  = parity_fault
                              & ((~st.fault_d) | (irq_mask_i[EV_ADDR_PARITY] & ~st.mask7_d));
        ev[EV_TTAG_WRAP]    = ttag_tick_i & (st.ttag == TTAG_TOP);
        if (in_rt && ext_mem_mgmt_i && sa_rollover_req_i) begin
            if (!cfg2_i[CFG2_INV_OVERWRITE]) begin
                ev[EV_CBUF_WRAP] = cbuf_top_access_i;
            end else begin
                ev[EV_CBUF_WRAP] = msg_end_i & msg_valid_i
                                   & (st.cbuf_pend | cbuf_top_access_i);
            end
        end
        ev[EV_CTRL_EOM]     = msg_end_i
                              & ((in_rt & ext_mem_mgmt_i & sa_eom_req_i)
                              | (in_bc & enh & cfg4_i[CFG4_WIDE_CTRL]
                              & ctrl_word_i[CTRL_EOM_REQ]));
        ev[EV_END_FRAME]    = in_bc & msg_count_wr_i & (msg_count_i == COUNT_END)
                              & ~stop_abort_i;
        ev[EV_FORMAT]       = (echo_check_i & transmitting_i & ~(in_rt & rt_broadcast_i)
                              & (~echo_valid_i | ~echo_sync_ok_i
                              | (last_tx_word_i != last_echo_word_i)))
                              | msg_error_i | resp_timeout_i;
        ev[EV_STATUS_SET]   = (in_bc & status_strobe_i
                              & ((status_word_i[15:11] != terminal_address_in_i)
                              | ((status_word_i & STS_CHECK_MASK) != sts_expect)))
                              | (in_rt & enh & cfg3_i[CFG3_EXT_MODECODE]
                              & mode_code_end_i & mode_code_enabled_i)
                              | (in_wmon & enh & cmd_word_strobe_i & cmd_word_valid_i
                              & (cmd_word_i == trigger_pattern_i));
        ev[EV_MSG_DONE]     = msg_end_i & (in_bc | in_rt | in_mmon);
    end

    // ----
    // flag register
    // ----
    always_comb begin
        next_st = st;
        next_st.fault_d = parity_fault;
        next_st.mask7_d = irq_mask_i[EV_ADDR_PARITY];
        if (ttag_tick_i) begin
            next_st.ttag = st.ttag + 16'h0001;
        end
        if (cbuf_top_access_i) begin
            next_st.cbuf_pend = 1'b1;
        end
        if (msg_end_i) begin
            next_st.cbuf_pend = 1'b0;
        end
        if ((flag_read_i && auto_clear_i) || irq_reset_i) begin
            next_st.flags = '0;
        end
        for (int i = 0; i <= EV_RAM_PARITY; i++) begin
            if (ev[i]) begin
                if (ext) begin
                    next_st.flags[i] = 1'b1;
                end else if (i <= EV_BASIC_TOP && irq_mask_i[i]) begin
                    next_st.flags[i] = 1'b1;
                end
            end
        end
        if (ext) begin
            next_st.irq = |(next_st.flags & irq_mask_i[14:0]);
        end else begin
            next_st.irq = |(next_st.flags[EV_BASIC_TOP:0] & irq_mask_i[EV_BASIC_TOP:0]);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign event_flag_register_o = {st.irq, st.flags};
    assign irq_o                 = st.irq;
    assign time_tag_o            = st.ttag;
endmodule
`default_nettype wire

// file: testbench/bie_event_checker.sv
// bie_event_checker: port-level assertions on the event flag logic
// assumes it is bound to bie_event_logic and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module bie_event_checker import bie_pkg::*; #(
    parameter int TX_LIMIT = 20
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] cfg2_i,
    input  wire logic [15:0] cfg3_i,
    input  wire logic [2:0]  mode_i,
    input  wire logic        flag_read_i,
    input  wire logic        auto_clear_i,
    input  wire logic        irq_reset_i,
    input  wire logic [4:0]  terminal_address_in_i,
    input  wire logic        terminal_address_parity_in_i,
    input  wire logic        encoder_active_i,
    input  wire logic        ttag_tick_i,
    input  wire logic        msg_end_i,
    input  wire logic        status_strobe_i,
    input  wire logic [15:0] status_word_i,
    input  wire logic [15:0] event_flag_register_o,
    input  wire logic        irq_o,
    input  wire logic [15:0] time_tag_o
);
    logic       ext;
    logic [7:0] act_cnt;
    assign ext = cfg3_i[15] & cfg2_i[15];
    // saturating count of consecutive encoder-active cycles
    always_ff @(posedge core_clk_i) begin
        act_cnt <= (rst_i | ~encoder_active_i) ? 8'h00 : act_cnt + {7'h00, ~&act_cnt};
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_IRQ_MIRROR: assert property (irq_o == event_flag_register_o[15])
        else $error("irq differs from flag bit 15");
    AST_BASIC_NO_EXT: assert property (!ext && event_flag_register_o[14:8] == 7'h00 |=> event_flag_register_o[14:8] == 7'h00)
        else $error("extended flag set in basic mode");
    AST_MSG_DONE: assert property (msg_end_i && mode_i == MODE_BC && ext |=> event_flag_register_o[0])
        else $error("end of message flag missing");
    AST_FLAG_HOLD: assert property (event_flag_register_o[0] && !(flag_read_i && auto_clear_i) && !irq_reset_i |=> event_flag_register_o[0])
        else $error("flag dropped without a clear");
    AST_TTAG_WRAP: assert property (ttag_tick_i && time_tag_o == TTAG_TOP && ext |=> time_tag_o == 16'h0000 && event_flag_register_o[6])
        else $error("time tag wrap not flagged");
    AST_TX_TIMEOUT: assert property (ext && act_cnt == 8'(TX_LIMIT + 2) |-> ##[0:2] event_flag_register_o[13])
        else $error("transmitter timeout not flagged");
    AST_ADDR_PARITY: assert property ($rose(~^{terminal_address_in_i, terminal_address_parity_in_i}) && ext |-> ##[1:2] event_flag_register_o[7])
        else $error("address parity fault not flagged");
    AST_STATUS_ADDR: assert property (status_strobe_i && mode_i == MODE_BC && ext && status_word_i[15:11] != terminal_address_in_i |=> event_flag_register_o[1])
        else $error("wrong status address not flagged");
endmodule
`default_nettype wire

// file: testbench/bie_host_model.sv
// bie_host_model: host side that reads and resets the event flags
// assumes requests change just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module bie_host_model (
    input  wire logic core_clk_i,
    input  wire logic rd_req_i,
    input  wire logic clr_req_i,
    output logic      flag_read_o,
    output logic      irq_reset_o
);
    // one-cycle register access, issued the edge after the request
    always @(posedge core_clk_i) begin
        flag_read_o <= rd_req_i;
        irq_reset_o <= clr_req_i;
    end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// tb: self-checking bench for the event flag logic
// assumes the checker and host model files are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
    import bie_pkg::*;
    logic        core_clk_i = 1'b0, rst_i = 1'b1;
    logic [15:0] cfg2_i = '0, cfg3_i = '0, cfg4_i = '0, irq_mask_i = '0, ctrl_word_i = '0, ev = '0;
    logic [15:0] msg_count_i = '0, last_tx_word_i = '0, last_echo_word_i = '0, status_word_i = '0;
    logic [15:0] cmd_word_i = '0, trigger_pattern_i = '0, event_flag_register_o, time_tag_o;
    logic [2:0]  mode_i = MODE_BC;
    logic [1:0]  term_clk_sel_i = TCLK_20M, retry_count_i = 2'h1;
    logic [4:0]  terminal_address_in_i = 5'h01;
    logic        terminal_address_parity_in_i = 0, transparent_mode_i = 0, ext_mem_mgmt_i = 0;
    logic        auto_clear_i = 1, rd_req = 0, clr_req = 0, msg_valid_i = 0, sa_eom_req_i = 0;
    logic        sa_rollover_req_i = 0, stop_abort_i = 0, transmitting_i = 1, rt_broadcast_i = 0;
    logic        echo_valid_i = 1, echo_sync_ok_i = 1, mode_code_enabled_i = 0, cmd_word_valid_i = 0;
    logic        transfer_request_out_i = 0, transfer_grant_in_n_i = 1, host_ready_out_n_i = 1;
    logic        host_strobe_in_n_i = 1, flag_read_i, irq_reset_i, irq_o;
    wire msg_end_i = ev[0], status_strobe_i = ev[1], retry_done_i = ev[2], msg_count_wr_i = ev[3];
    wire echo_check_i = ev[4], msg_error_i = ev[5], resp_timeout_i = ev[6], ttag_tick_i = ev[7];
    wire cmd_stack_push_i = ev[8], encoder_active_i = ev[9], ram_parity_err_i = ev[10];
    wire mon_cmd_push_i = ev[11], mon_dat_push_i = ev[12], cbuf_top_access_i = ev[13];
    wire mode_code_end_i = ev[14], cmd_word_strobe_i = ev[15];
    int unsigned n_mismatch = 0, n_compared = 0;
    logic [31:0] seed = 32'd60716;
    bie_event_logic #(.TX_LIMIT(20)) bie_event_logic_inst (.*);
    bie_host_model bie_host_model_inst (.core_clk_i(core_clk_i), .rd_req_i(rd_req),
        .clr_req_i(clr_req), .flag_read_o(flag_read_i), .irq_reset_o(irq_reset_i));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] sts_exp(input logic [15:0] w, input logic b5, xm);
        logic [15:0] e;
        e = (!xm && b5) ? STS_BCAST_BIT : 16'h0000;
        return (w[15:11] != 5'h01 || (w & STS_CHECK_MASK) != e) ? 16'h0002 : 16'h0000;
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic fl(input logic [15:0] e);
        chk("flags", event_flag_register_o, e);
        chk("irq", {15'h0000, irq_o}, {15'h0000, e[15]});
    endtask
    // pulses event lines for n edges
    task automatic hold(input logic [15:0] m, input int n);
        @(posedge core_clk_i);
        ev <= m;
        repeat (n) @(posedge core_clk_i);
        ev <= '0;
        #1;
    endtask
    task automatic host(input logic rd);
        @(posedge core_clk_i);
        rd_req <= rd;
        clr_req <= ~rd;
        @(posedge core_clk_i);
        rd_req <= 1'b0;
        clr_req <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----
    // clock, watchdog and tests
    // ----
    initial forever #2 core_clk_i = ~core_clk_i;
    initial begin
        #(4 * 80000);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        logic [31:0] r;
        logic [15:0] w;
        logic        b5;
        logic        xm;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        fl(16'h0000);
        chk("time tag", time_tag_o, 16'h0000);
        hold(16'h0001, 1);
        fl(16'h0000);
        irq_mask_i <= 16'h0101;
        hold(16'h0005, 1);
        fl(16'h8001);
        host(1'b1);
        fl(16'h0000);
        $display("test basic mode done");
        cfg3_i <= 16'ha000;
        cfg2_i <= 16'h8000;
        irq_mask_i <= 16'h0100;
        hold(16'h0001, 1);
        fl(16'h0001);
        hold(16'h0004, 1);
        fl(16'h8101);
        host(1'b0);
        retry_count_i <= 2'h0;
        hold(16'h0004, 1);
        fl(16'h0000);
        cfg4_i <= 16'h1000;
        ctrl_word_i <= 16'h0010;
        hold(16'h0001, 1);
        fl(16'h0011);
        host(1'b0);
        $display("test extended mode done");
        for (int i = 0; i < 12; i++) begin
            r = xs();
            w = (i == 0) ? 16'h0810 : (r[0] ? {5'h01, r[11:1] & r[22:12]} : r[31:16]);
            b5 = (i == 0) | r[23];
            xm = (i != 0) & r[24];
            status_word_i <= w;
            ctrl_word_i <= {10'h000, b5, 5'h00};
            cfg4_i <= {4'h0, xm, 11'h000};
            hold(16'h0002, 1);
            fl(sts_exp(w, b5, xm));
            host(1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            msg_count_i <= (i == 2) ? 16'hfffe : COUNT_END;
            stop_abort_i <= (i == 1);
            hold(16'h0008, 1);
            fl((i == 0) ? 16'h0008 : 16'h0000);
            host(1'b0);
        end
        for (int i = 0; i < 5; i++) begin
            last_echo_word_i <= (i == 1) ? 16'h0001 : 16'h0000;
            echo_valid_i <= (i != 2);
            hold(16'h0010 << ((i > 2) ? i - 2 : 0), 1);
            fl((i == 0) ? 16'h0000 : 16'h0004);
            host(1'b0);
        end
        $display("test status frame format done");
        hold(16'h0100, 511);
        fl(16'h0000);
        hold(16'h0100, 1);
        hold(16'h0000, 1);
        fl(16'h1000);
        host(1'b0);
        hold(16'h0200, 19);
        fl(16'h0000);
        hold(16'h0200, 30);
        fl(16'h2000);
        host(1'b0);
        cfg2_i <= 16'h0000;
        irq_mask_i <= 16'h2000;
        hold(16'h0200, 30);
        fl(16'h0000);
        cfg2_i <= 16'h8000;
        irq_mask_i <= 16'h0080;
        $display("test stack and timeout done");
        terminal_address_parity_in_i <= 1'b1;
        hold(16'h0000, 2);
        fl(16'h8080);
        host(1'b0);
        hold(16'h0000, 2);
        fl(16'h0000);
        terminal_address_parity_in_i <= 1'b0;
        hold(16'h0000, 2);
        terminal_address_parity_in_i <= 1'b1;
        hold(16'h0000, 2);
        fl(16'h8080);
        terminal_address_parity_in_i <= 1'b0;
        host(1'b0);
        hold(16'h0080, 65535);
        chk("time tag", time_tag_o, TTAG_TOP);
        hold(16'h0080, 1);
        chk("time tag", time_tag_o, 16'h0000);
        fl(16'h0040);
        $display("test parity and time tag done");
        print_verdict();
    end
endmodule
bind bie_event_logic bie_event_checker #(.TX_LIMIT(TX_LIMIT)) bie_event_checker_inst (.*);
`default_nettype wire
